/* src/spram_pkg.sv */
// Constants, field layouts and carrier types of the single-port RAM block.
// Assumes one clock domain and an APB master on the register side.
package spram_pkg;

    // Array shape, fixed at build time
    localparam int DATA_W = 20;
    localparam int ADDR_W = 5;
    localparam int DEPTH = 32;
    localparam int BYTE_W = 10;
    localparam int BE_W = DATA_W / BYTE_W;
    // Write width over read width; one port, so always one
    localparam int PORT_RATIO = 1;

    // Implementation target encodings
    localparam logic [1:0] TGT_AUTO = 2'h0;
    localparam logic [1:0] TGT_DIST = 2'h1;
    localparam logic [1:0] TGT_BLOCK = 2'h2;
    localparam logic [1:0] TGT_LOGIC_CELL = 2'h3;

    // Block depth slice limit encodings
    localparam logic [1:0] MD_AUTO = 2'h0;
    localparam logic [1:0] MD_32_OR_512 = 2'h1;
    localparam logic [1:0] MD_1024 = 2'h2;
    localparam logic [1:0] MD_2048 = 2'h3;
    localparam int DIST_MAX_DEPTH = 32;
    localparam int BLK_DEPTH_A = 512;
    localparam int BLK_DEPTH_B = 1024;
    localparam int BLK_DEPTH_C = 2048;

    // Bit positions in the clear-select field
    localparam int ACLR_DATA = 0;
    localparam int ACLR_WREN = 1;
    localparam int ACLR_ADDR = 2;
    localparam int ACLR_Q = 3;
    localparam int ACLR_BE = 4;

    // Register map, byte addresses
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_INFO = 12'h008;
    localparam logic [11:0] OFS_MEM = 12'h100;
    localparam logic [11:0] MEM_SPAN = 12'h080;

    // Status field positions
    localparam int ST_LEGAL = 0;
    localparam int ST_BE_ACT = 1;
    localparam int ST_NBE_X = 2;
    localparam int ST_WREN = 3;
    localparam int ST_ADDR_LSB = 8;

    // Info field positions
    localparam int INF_DATA_LSB = 0;
    localparam int INF_BYTE_LSB = 8;
    localparam int INF_DEPTH_LSB = 16;

    typedef struct packed {
        logic [1:0] target;
        logic [1:0] max_depth;
        logic sclr_on;
        logic [4:0] aclr_sel;
        logic nbe_x;
        logic rdw_new;
        logic force_zero;
        logic rden_on;
        logic byte_en_on;
        logic stall_on;
        logic use_out_ce;
        logic use_in_ce;
        logic dual_clk;
        logic reg_out;
        logic reg_addr;
        logic reg_in;
    } spram_ctrl_type;

    localparam int CTRL_W = $bits(spram_ctrl_type);
    localparam spram_ctrl_type CTRL_RST = 22'h00_0003;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } spram_apb_req_type;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic wren;
        logic [ADDR_W-1:0] address;
        logic [BE_W-1:0] byteena;
        logic rden;
        logic ce_in;
        logic ce_out;
        logic addr_stall;
        logic aclr;
        logic sclr;
    } spram_fab_req_type;

    typedef struct packed {
        logic [DEPTH-1:0][DATA_W-1:0] mem;
        spram_ctrl_type ctrl;
        logic [DATA_W-1:0] data_r;
        logic wren_r;
        logic [BE_W-1:0] be_r;
        logic rden_r;
        logic [ADDR_W-1:0] addr_r;
        logic [DATA_W-1:0] lat_r;
        logic [DATA_W-1:0] q_r;
        logic [31:0] prdata_r;
        logic pready_r;
        logic pslverr_r;
    } spram_state_type;

endpackage : spram_pkg

/* src/spram_top.sv */
// Single-port synchronous RAM with APB configuration and preload window.
// Assumes fabric inputs and the APB master are synchronous to CLK.
//
// What this block does
// - Depth limit: 32 on distributed, 512/1024/2048 on block, or automatic.
// - Single-clock mode: one clock enable governs every register.
// - Dual mode: input registers and output registers use separate enables.
// - Data/wren, address and read data registering each selectable.
// - Registered ports update only while their clock enable is high.
// - Input and output clock enables selectable independently.
// - Active-high address stall holds the captured address.
// - Byte-enabled write changes only enabled bytes; others keep contents.
// - Byte size 5/10 on distributed, 8/9/10 on block; width divisible.
// - Byte enables offered only with port width ratio 1 or 2.
// - Clear resets only selected registered ports.
// - Synchronous clear zeroes the registered read data.
// - Optional read enable; reads happen only while it is high.
// - Don't-care mode may return anything for same-address read-write.
// - New-data mode presents the word being written in that cycle.
// - Masked bytes may read unknown; not on block target with new data.
// - Contents start at zero; loadable by software before use.
// - Force-to-zero drives read data to zero while read enable is low.
// - With unregistered output, clears act on the output latch.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps

module spram_top (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire spram_pkg::spram_apb_req_type APB_REQ,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire spram_pkg::spram_fab_req_type FAB_REQ,
    output logic [spram_pkg::DATA_W-1:0] Q
);
    import spram_pkg::*;

    spram_state_type state_r;
    spram_state_type state_nxt;

    // Whether the selected target and depth slice can be built
    function automatic logic cfg_legal(input spram_ctrl_type c);
        logic ok;
        ok = 1'b0;
        case (c.target)
            TGT_AUTO: begin
                ok = (c.max_depth == MD_AUTO);
            end
            TGT_DIST: begin
                ok = (c.max_depth == MD_AUTO
                      || (c.max_depth == MD_32_OR_512
                          && DEPTH <= DIST_MAX_DEPTH))
                     && (BYTE_W == 5 || BYTE_W == 10);
            end
            TGT_BLOCK: begin
                ok = (BYTE_W == 8 || BYTE_W == 9 || BYTE_W == 10);
            end
            TGT_LOGIC_CELL: begin
                ok = (c.max_depth == MD_AUTO);
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        return ok && (DATA_W % BYTE_W == 0);
    endfunction : cfg_legal

    // Combinational helpers
    spram_ctrl_type c;
    logic ce_in;
    logic ce_out;
    logic addr_hold;
    logic [DATA_W-1:0] d_eff;
    logic we_eff;
    logic [BE_W-1:0] be_eff;
    logic rden_src;
    logic rd_eff;
    logic [ADDR_W-1:0] a_eff;
    logic be_act;
    logic nbe_x_act;
    logic [DATA_W-1:0] old_w;
    logic [DATA_W-1:0] new_w;
    logic [DATA_W-1:0] rd_w;
    logic do_write;
    logic apb_done;
    logic apb_setup;
    logic in_mem;
    logic [ADDR_W-1:0] apb_idx;
    logic [11:0] mem_off;
    logic [31:0] rd_bus;
    logic rd_err;

    always_comb begin
        state_nxt = state_r;
        c = state_r.ctrl;
        old_w = '0;
        new_w = '0;
        rd_w = '0;
        rd_bus = 32'h0000_0000;
        rd_err = 1'b0;

        // Enables: single mode shares one enable with the output side
        ce_in = !c.use_in_ce || FAB_REQ.ce_in;
        if (c.dual_clk) begin
            ce_out = !c.use_out_ce || FAB_REQ.ce_out;
        end else begin
            ce_out = ce_in;
        end
        addr_hold = c.stall_on && FAB_REQ.addr_stall;

        // Input registers
        if (ce_in) begin
            state_nxt.data_r = FAB_REQ.data;
            state_nxt.wren_r = FAB_REQ.wren;
            state_nxt.be_r = FAB_REQ.byteena;
            state_nxt.rden_r = FAB_REQ.rden;
            if (!addr_hold) begin
                state_nxt.addr_r = FAB_REQ.address;
            end
        end

        // Port values seen by the array, registered or direct
        d_eff = c.reg_in ? state_r.data_r : FAB_REQ.data;
        we_eff = c.reg_in ? state_r.wren_r : FAB_REQ.wren;
        be_eff = c.reg_in ? state_r.be_r : FAB_REQ.byteena;
        rden_src = c.reg_in ? state_r.rden_r : FAB_REQ.rden;
        a_eff = c.reg_addr ? state_r.addr_r : FAB_REQ.address;

        be_act = c.byte_en_on
                 && (PORT_RATIO == 1 || PORT_RATIO == 2);
        // Masked-unknown read is refused on block target with new data
        nbe_x_act = c.nbe_x && be_act
                    && !(c.target == TGT_BLOCK && c.rdw_new);
        rd_eff = !c.rden_on || rden_src;
        do_write = we_eff && ce_in;

        old_w = state_r.mem[a_eff];
        for (int b = 0; b < BE_W; b++) begin
            if (!be_act || be_eff[b]) begin
                new_w[b*BYTE_W +: BYTE_W] = d_eff[b*BYTE_W +: BYTE_W];
            end else begin
                new_w[b*BYTE_W +: BYTE_W] = old_w[b*BYTE_W +: BYTE_W];
            end
        end

        // Don't-care returns the old word, an allowed value
        if (do_write && c.rdw_new) begin
            rd_w = new_w;
        end else begin
            rd_w = old_w;
        end
        if (do_write && nbe_x_act) begin
            for (int b = 0; b < BE_W; b++) begin
                if (!be_eff[b]) begin
                    rd_w[b*BYTE_W +: BYTE_W] = '0;
                end
            end
        end

        // APB decode
        apb_setup = APB_REQ.psel && !APB_REQ.penable;
        apb_done = APB_REQ.psel && APB_REQ.penable && state_r.pready_r;
        mem_off = APB_REQ.paddr - OFS_MEM;
        in_mem = (APB_REQ.paddr >= OFS_MEM)
                 && (APB_REQ.paddr < OFS_MEM + MEM_SPAN);
        apb_idx = mem_off[ADDR_W+1:2];

        // Software preload comes first so a fabric write wins
        if (apb_done && APB_REQ.pwrite) begin
            if (APB_REQ.paddr == OFS_CTRL) begin
                state_nxt.ctrl = spram_ctrl_type'(APB_REQ.pwdata[CTRL_W-1:0]);
            end else if (in_mem) begin
                state_nxt.mem[apb_idx] = APB_REQ.pwdata[DATA_W-1:0];
            end
        end
        if (do_write) begin
            state_nxt.mem[a_eff] = new_w;
        end

        // Output latch: capture on read, zero or hold otherwise
        if (ce_out && rd_eff) begin
            state_nxt.lat_r = rd_w;
        end else if (ce_out && c.force_zero && !rd_eff) begin
            state_nxt.lat_r = '0;
        end
        // Else the latch keeps its value

        if (c.reg_out) begin
            if (ce_out) begin
                state_nxt.q_r = state_r.lat_r;
            end
        end else begin
            state_nxt.q_r = state_nxt.lat_r;
        end

        if (c.sclr_on && FAB_REQ.sclr) begin
            state_nxt.lat_r = '0;
            state_nxt.q_r = '0;
        end

        // Clear touches only the selected ports
        if (FAB_REQ.aclr) begin
            if (c.aclr_sel[ACLR_DATA]) begin
                state_nxt.data_r = '0;
            end
            if (c.aclr_sel[ACLR_WREN]) begin
                state_nxt.wren_r = 1'b0;
            end
            if (c.aclr_sel[ACLR_ADDR]) begin
                state_nxt.addr_r = '0;
            end
            if (c.aclr_sel[ACLR_BE]) begin
                state_nxt.be_r = '0;
            end
            if (c.aclr_sel[ACLR_Q]) begin
                state_nxt.lat_r = '0;
                state_nxt.q_r = '0;
            end
        end

        // Read data is prepared at setup and held through the access
        if (APB_REQ.paddr == OFS_CTRL) begin
            rd_bus[CTRL_W-1:0] = c;
        end else if (APB_REQ.paddr == OFS_STATUS) begin
            rd_bus[ST_LEGAL] = cfg_legal(c);
            rd_bus[ST_BE_ACT] = be_act;
            rd_bus[ST_NBE_X] = nbe_x_act;
            rd_bus[ST_WREN] = state_r.wren_r;
            rd_bus[ST_ADDR_LSB +: ADDR_W] = state_r.addr_r;
        end else if (APB_REQ.paddr == OFS_INFO) begin
            rd_bus[INF_DATA_LSB +: 8] = 8'(DATA_W);
            rd_bus[INF_BYTE_LSB +: 8] = 8'(BYTE_W);
            rd_bus[INF_DEPTH_LSB +: 16] = 16'(DEPTH);
        end else if (in_mem) begin
            rd_bus[DATA_W-1:0] = state_r.mem[apb_idx];
        end else begin
            rd_err = 1'b1;
        end

        // No wait states: pready rises in the first access cycle
        state_nxt.pready_r = APB_REQ.psel && !apb_done;
        if (apb_setup) begin
            state_nxt.prdata_r = APB_REQ.pwrite ? 32'h0000_0000 : rd_bus;
            state_nxt.pslverr_r = rd_err;
        end else if (apb_done) begin
            state_nxt.prdata_r = 32'h0000_0000;
            state_nxt.pslverr_r = 1'b0;
        end
    end

    // Contents start at zero
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_r <= '0;
            state_r.ctrl <= CTRL_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign PRDATA = state_r.prdata_r;
    assign PREADY = state_r.pready_r;
    assign PSLVERR = state_r.pslverr_r;
    assign Q = state_r.q_r;

endmodule : spram_top

/* sim/spram_fab_model.sv */
// Fabric-side driver model for the single-port RAM block.
// Assumes the caller steps it once per CLK edge through drive().
`timescale 1ns/1ps

module spram_fab_model (
    input wire logic CLK,
    output spram_pkg::spram_fab_req_type FAB
);
    import spram_pkg::*;

    logic ce_in_m = 1'b1;
    logic ce_out_m = 1'b1;

    initial FAB = '0;

    // Enables used from the next drive() on
    task automatic set_ce(input logic ci, input logic co);
        ce_in_m = ci;
        ce_out_m = co;
    endtask : set_ce

    // Flags m: wren, rden, stall, sclr, aclr; data turns over when idle
    task automatic drive(input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d,
                         input logic [BE_W-1:0] be, input logic [4:0] m);
        @(posedge CLK);
        FAB <= '{data: m[4] ? d : ~FAB.data, wren: m[4], address: a,
                 byteena: be, rden: m[3], ce_in: ce_in_m, ce_out: ce_out_m,
                 addr_stall: m[2], aclr: m[0], sclr: m[1]};
    endtask : drive
endmodule : spram_fab_model

/* sim/spram_properties.sv */
// Port-level checker for the single-port RAM block.
// Assumes CTRL writes go over APB; it shadows them to know the mode.
`timescale 1ns/1ps

module spram_checker (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire spram_pkg::spram_apb_req_type APB_REQ,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire spram_pkg::spram_fab_req_type FAB_REQ,
    input wire logic [spram_pkg::DATA_W-1:0] Q
);
    import spram_pkg::*;
    spram_ctrl_type ctrl_r;
    logic setup;
    logic bad;
    logic quiet;
    assign setup = APB_REQ.psel && !APB_REQ.penable;
    assign bad = !(APB_REQ.paddr inside {OFS_CTRL, OFS_STATUS, OFS_INFO})
        && !(APB_REQ.paddr >= OFS_MEM && APB_REQ.paddr < OFS_MEM + MEM_SPAN);
    // Clock enables kept off, else the output may legally freeze
    assign quiet = ctrl_r.rden_on && !FAB_REQ.rden && !ctrl_r.use_in_ce
                   && !ctrl_r.use_out_ce;

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ctrl_r <= CTRL_RST;
        end else if (APB_REQ.psel && APB_REQ.penable && PREADY
                     && APB_REQ.pwrite && APB_REQ.paddr == OFS_CTRL) begin
            ctrl_r <= spram_ctrl_type'(APB_REQ.pwdata[CTRL_W-1:0]);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    AST_READY_PULSE: assert property (setup |=> PREADY ##1 !PREADY)
        else $error("ready not one cycle after setup");
    AST_READY_CAUSE: assert property (PREADY |-> $past(setup))
        else $error("ready without setup");
    AST_ERR_UNMAPPED: assert property (setup && bad |=> PSLVERR
        && PRDATA == 32'h0000_0000)
        else $error("unmapped access not refused");
    AST_ERR_MAPPED: assert property (setup && !bad |=> !PSLVERR)
        else $error("mapped access refused");
    AST_RDATA_IDLE: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
        else $error("read data outside access");
    AST_FORCE_ZERO: assert property ((quiet && ctrl_r.force_zero)
        [*5] |-> Q == '0)
        else $error("output not forced to zero");
    AST_HOLD: assert property ((quiet && !ctrl_r.force_zero
        && !FAB_REQ.sclr && !FAB_REQ.aclr)[*5] |=> $stable(Q))
        else $error("output moved without read");
    AST_SCLR: assert property (ctrl_r.sclr_on && FAB_REQ.sclr
        |=> Q == '0)
        else $error("sync clear missed");
    AST_ACLR_Q: assert property (ctrl_r.aclr_sel[ACLR_Q]
        && FAB_REQ.aclr |=> Q == '0)
        else $error("selected clear missed");
endmodule : spram_checker

bind spram_top spram_checker chk (.CLK(CLK), .SYS_RST(SYS_RST),
    .APB_REQ(APB_REQ), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FAB_REQ(FAB_REQ), .Q(Q));

/* sim/tb_top.sv */
// Self-checking bench for the single-port RAM block.
// Assumes zero-wait APB answers and the fabric model for the data port.
`timescale 1ns/1ps

module tb_top;
    import spram_pkg::*;
    localparam logic [21:0] CLR_CFG [3] = '{22'h02_0003, 22'h00_8003,
                                           22'h00_0003};
    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    spram_apb_req_type apb_q = '0;
    spram_fab_req_type fab_q;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic [DATA_W-1:0] Q;
    logic [31:0] rd;
    logic er;
    logic [DATA_W-1:0] w2;
    int n_errors = 0;
    int n_tests = 0;

    always #5 CLK = ~CLK;

    spram_top uut (.CLK(CLK), .SYS_RST(SYS_RST), .APB_REQ(apb_q),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .FAB_REQ(fab_q), .Q(Q));
    spram_fab_model fab (.CLK(CLK), .FAB(fab_q));

    task automatic report_and_stop();
        if (n_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge CLK);
        apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                   pwdata: wd};
        @(posedge CLK);
        apb_q.penable <= 1'b1;
        @(posedge CLK);
        while (PREADY !== 1'b1) @(posedge CLK);
        rd = PRDATA;
        er = PSLVERR;
        apb_q <= '0;
    endtask : apb

    // Looks at Q settled after the (n-1)th edge, then steps one more edge
    task automatic fq(input string nm, input logic [DATA_W-1:0] e,
                      input int n = 3);
        repeat (n - 1) @(posedge CLK);
        @(negedge CLK);
        chk(nm, {12'h000, e}, {12'h000, Q});
        @(posedge CLK);
    endtask : fq

    initial begin
        repeat (16) @(posedge CLK);
        SYS_RST <= 1'b0;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl_rst", 32'h0000_0003, rd);
        apb(1'b0, OFS_INFO, 32'h0);
        chk("info", 32'h0020_0A14, rd);
        apb(1'b0, 12'h200, 32'h0);
        chk("unmapped", 32'h0000_0001, {31'h0, er});
        apb(1'b0, OFS_MEM + 12'h014, 32'h0);
        chk("mem_init", 32'h0000_0000, rd);
        apb(1'b1, OFS_MEM + 12'h008, 32'hFFF1_2345);
        apb(1'b0, OFS_MEM + 12'h008, 32'h0);
        chk("preload", 32'h0001_2345, rd);
        fab.drive(5'h02, 20'h0_0000, 2'h3, 5'h08);
        fq("q_read", 20'h1_2345);
        apb(1'b1, OFS_CTRL, 32'h0000_0083);
        fab.drive(5'h02, 20'hA_BCDE, 2'h1, 5'h18);
        fab.drive(5'h02, 20'h0_0000, 2'h0, 5'h08);
        w2 = (20'h1_2345 & 20'hF_FC00) | (20'hA_BCDE & 20'h0_03FF);
        fq("q_byte_en", w2);
        apb(1'b1, OFS_CTRL, 32'h0000_0403);
        fab.drive(5'h04, 20'h5_A5A5, 2'h3, 5'h18);
        fq("q_new_data", 20'h5_A5A5);
        apb(1'b1, OFS_CTRL, 32'h0000_0043);
        fab.drive(5'h02, 20'h0_0000, 2'h0, 5'h08);
        fab.drive(5'h04, 20'h0_0000, 2'h0, 5'h0C);
        fq("q_stall", w2);
        apb(1'b1, OFS_CTRL, 32'h0000_0303);
        fab.drive(5'h02, 20'h0_0000, 2'h0, 5'h00);
        fq("q_force_zero", 20'h0_0000);
        apb(1'b1, OFS_CTRL, 32'h0000_0103);
        fab.drive(5'h02, 20'h0_0000, 2'h0, 5'h08);
        fq("q_rden", w2);
        fab.drive(5'h04, 20'h0_0000, 2'h0, 5'h00);
        fq("q_hold", w2);
        // Sync clear, selected async clear, then unselected async clear
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, OFS_CTRL, {10'h000, CLR_CFG[i]});
            fab.drive(5'h02, 20'h0_0000, 2'h0, 5'h08);
            fq("q_pre_clear", w2);
            fab.drive(5'h02, 20'h0_0000, 2'h0, i == 0 ? 5'h0A : 5'h09);
            fq("q_clear", i == 2 ? w2 : 20'h0_0000);
        end
        // Output register with its own clock enable
        apb(1'b1, OFS_CTRL, 32'h0000_002F);
        fab.set_ce(1'b1, 1'b1);
        fab.drive(5'h04, 20'h0_0000, 2'h0, 5'h08);
        fq("q_out_reg", 20'h5_A5A5, 4);
        fab.set_ce(1'b1, 1'b0);
        fab.drive(5'h02, 20'h0_0000, 2'h0, 5'h08);
        fq("q_out_ce", 20'h5_A5A5);
        fab.set_ce(1'b1, 1'b1);
        fab.drive(5'h02, 20'h0_0000, 2'h0, 5'h08);
        fq("q_out_lag", 20'h5_A5A5, 2);
        fq("q_out_new", w2, 2);
        // Write refused while the input enable is low
        apb(1'b1, OFS_CTRL, 32'h0000_0013);
        fab.set_ce(1'b0, 1'b0);
        fab.drive(5'h06, 20'h3_3333, 2'h3, 5'h18);
        fab.set_ce(1'b1, 1'b1);
        fab.drive(5'h06, 20'h0_0000, 2'h0, 5'h08);
        fq("q_in_ce", 20'h0_0000, 4);
        // Masked byte reads zero while its word is written
        apb(1'b1, OFS_CTRL, 32'h0000_0883);
        fab.drive(5'h02, 20'h0_0155, 2'h1, 5'h18);
        fab.drive(5'h02, 20'h0_0000, 2'h0, 5'h08);
        fq("q_nbe_x", w2 & 20'h0_03FF, 2);
        fq("q_nbe_word", (w2 & 20'hF_FC00) | 20'h0_0155, 2);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("status_nbe", 32'h0000_0207, rd);
        apb(1'b1, OFS_CTRL, 32'h0020_0C83);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("status_blk_new", 32'h0000_0203, rd);
        apb(1'b1, OFS_CTRL, 32'h0018_0003);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("status_bad_depth", 32'h0000_0200, rd);
        // Live address: word shows one edge after it is driven
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        fab.drive(5'h04, 20'h0_0000, 2'h0, 5'h08);
        fq("q_live_addr", 20'h5_A5A5, 2);
        report_and_stop();
    end

    // Whole run needs under two hundred cycles; this bounds a hang
    initial begin
        #200000;
        n_errors++;
        report_and_stop();
    end
endmodule : tb_top
